// >>> dcf_defines.vh
// Constants for the dual-clock deep FIFO block
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH
// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define DCF_DATA_W        9
`define DCF_ADDR_W        16
`define DCF_PTR_W         17
`define DCF_DEPTH         17'h10000
`define DCF_HALF          17'h08000
`define DCF_OFS_W         16
// ----------------------------------------------------------------
// Default offsets and timing counts
// ----------------------------------------------------------------
`define DCF_OFS_SHORT     16'h007f
`define DCF_OFS_LONG      16'h03ff
`define DCF_FALL_TRANS    2'h3
`define DCF_RT_HOLD       2'h2
// ----------------------------------------------------------------
// Register map (byte addresses) and field positions
// ----------------------------------------------------------------
`define DCF_REG_STATUS    4'h0
`define DCF_REG_OFFSETS   4'h4
`define DCF_REG_CONTROL   4'h8
`define DCF_ST_EMPTY      17
`define DCF_ST_FULL       18
`define DCF_ST_FALL       19
`define DCF_ST_SERIAL     20
`define DCF_CTL_PRST      0
`define DCF_RESP_OKAY     2'h0
`define DCF_RESP_SLVERR   2'h2
`endif

// >>> dcf_fifo.v
// Dual-clock deep 9-bit FIFO with programmable flags and AXI4-Lite status
`timescale 1ns/1ps
`include "dcf_defines.vh"
module dcf_fifo (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        writeClk,
  input  wire        writeEnableN,
  input  wire [8:0]  writeDataIn,
  input  wire        serialLoadEnableN,
  input  wire        modeSelectSerialIn,
  input  wire        offsetLoadN,
  input  wire        readClk,
  input  wire        readEnableN,
  input  wire        outputEnableN,
  input  wire        fullResetN,
  input  wire        partialResetN,
  input  wire        rewindN,
  output wire [8:0]  readDataOut,
  output wire        readDataOeN,
  output wire        fullOrInputReady,
  output wire        emptyOrOutputReady,
  output wire        almostFullN,
  output wire        almostEmptyN,
  output wire        halfFullN,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  reg [8:0]   memArray [0:65535];
  reg [16:0]  wrPtr_reg;
  reg [16:0]  rdPtr_reg;
  reg [8:0]   dataOut_reg;
  reg         fallThrough_reg;
  reg         serialMethod_reg;
  reg [15:0]  emptyOfs_reg;
  reg [15:0]  fullOfs_reg;
  reg [1:0]   loadIdx_reg;
  reg [1:0]   readIdx_reg;
  reg         outValid_reg;
  reg [1:0]   transCnt_reg;
  reg [1:0]   rtHold_reg;
  reg         writeClkPrev_reg;
  reg         readClkPrev_reg;
  reg         fullFlag_reg;
  reg         emptyFlag_reg;
  reg         almostFull_reg;
  reg         almostEmpty_reg;
  reg         halfFull_reg;
  reg         softPartial_reg;

  // ----------------------------------------------------------------
  // Pin edge detection and derived conditions
  // ----------------------------------------------------------------
  wire        writeEdge   = writeClk & ~writeClkPrev_reg;
  wire        readEdge    = readClk & ~readClkPrev_reg;
  wire        readTrans   = readClk ^ readClkPrev_reg;
  wire        inFullReset = ~fullResetN;
  wire        inPartial   = ~partialResetN | softPartial_reg;
  wire [16:0] wordCount   = wrPtr_reg - rdPtr_reg;
  wire        memEmpty    = (wordCount == 17'h00000);
  wire        memFull     = (wordCount == `DCF_DEPTH);
  wire        ofsAccess   = ~offsetLoadN;
  wire        doWrite     = writeEdge & ~writeEnableN & ~ofsAccess & ~memFull;
  wire        doParLoad   = writeEdge & ~writeEnableN & ofsAccess & ~serialMethod_reg;
  wire        doSerial    = writeEdge & ~serialLoadEnableN & ofsAccess & serialMethod_reg;
  wire        doOfsRead   = readEdge & ~readEnableN & ofsAccess;
  wire        doRewind    = readEdge & ~rewindN;
  wire        fallWait    = fallThrough_reg & ~outValid_reg & ~memEmpty;
  wire        fallLoad    = fallWait & readTrans & (transCnt_reg == `DCF_FALL_TRANS - 2'h1);
  wire        userRead    = readEdge & ~readEnableN & ~ofsAccess & ~memEmpty &
                            (~fallThrough_reg | outValid_reg);
  wire        doRead      = ~doRewind & (userRead | fallLoad);
  wire        fallDrain   = fallThrough_reg & readEdge & ~readEnableN & ~ofsAccess &
                            outValid_reg & memEmpty;

  // Offset chunk selected for a parallel read
  reg [8:0] ofsChunk;
  always @* begin
    case (readIdx_reg)
      2'h0:    ofsChunk = emptyOfs_reg[8:0];
      2'h1:    ofsChunk = {2'h0, emptyOfs_reg[15:9]};
      2'h2:    ofsChunk = fullOfs_reg[8:0];
      default: ofsChunk = {2'h0, fullOfs_reg[15:9]};
    endcase
  end

  // ----------------------------------------------------------------
  // Memory write port, no reset on the array
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (doWrite & ~inFullReset & ~inPartial) begin
      memArray[wrPtr_reg[15:0]] <= writeDataIn;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and output register
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_reg        <= 17'h00000;
      rdPtr_reg        <= 17'h00000;
      dataOut_reg      <= 9'h000;
      outValid_reg     <= 1'b0;
      transCnt_reg     <= 2'h0;
      rtHold_reg       <= 2'h0;
      writeClkPrev_reg <= 1'b0;
      readClkPrev_reg  <= 1'b0;
    end else begin
      writeClkPrev_reg <= writeClk;
      readClkPrev_reg  <= readClk;
      if (inFullReset | inPartial) begin
        wrPtr_reg    <= 17'h00000;
        rdPtr_reg    <= 17'h00000;
        dataOut_reg  <= 9'h000;
        outValid_reg <= 1'b0;
        transCnt_reg <= 2'h0;
        rtHold_reg   <= 2'h0;
      end else begin
        // Pointers wrap naturally through the extra bit
        if (doWrite) begin
          wrPtr_reg <= wrPtr_reg + 17'h00001;
        end
        if (doRewind) begin
          rdPtr_reg    <= 17'h00000;
          rtHold_reg   <= `DCF_RT_HOLD;
          outValid_reg <= 1'b0;
          transCnt_reg <= 2'h0;
        end else begin
          if (readEdge && rtHold_reg != 2'h0) begin
            rtHold_reg <= rtHold_reg - 2'h1;
          end
          if (doRead) begin
            rdPtr_reg    <= rdPtr_reg + 17'h00001;
            dataOut_reg  <= memArray[rdPtr_reg[15:0]];
            outValid_reg <= 1'b1;
          end else if (doOfsRead) begin
            dataOut_reg <= ofsChunk;
          end else if (fallDrain) begin
            outValid_reg <= 1'b0;
          end
          // Count read clock transitions before the first word falls
          if (fallWait & ~fallLoad) begin
            transCnt_reg <= transCnt_reg + {1'b0, readTrans};
          end else begin
            transCnt_reg <= 2'h0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration capture and offset programming
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fallThrough_reg  <= 1'b0;
      serialMethod_reg <= 1'b1;
      emptyOfs_reg     <= `DCF_OFS_LONG;
      fullOfs_reg      <= `DCF_OFS_LONG;
      loadIdx_reg      <= 2'h0;
      readIdx_reg      <= 2'h0;
    end else if (inFullReset) begin
      fallThrough_reg  <= modeSelectSerialIn;
      serialMethod_reg <= offsetLoadN;
      emptyOfs_reg     <= offsetLoadN ? `DCF_OFS_LONG : `DCF_OFS_SHORT;
      fullOfs_reg      <= offsetLoadN ? `DCF_OFS_LONG : `DCF_OFS_SHORT;
      loadIdx_reg      <= 2'h0;
      readIdx_reg      <= 2'h0;
    end else if (inPartial) begin
      loadIdx_reg <= 2'h0;
      readIdx_reg <= 2'h0;
    end else begin
      if (doSerial) begin
        // LSB of empty offset first, full offset last
        {fullOfs_reg, emptyOfs_reg} <= {modeSelectSerialIn, fullOfs_reg,
                                        emptyOfs_reg[15:1]};
      end else if (doParLoad) begin
        case (loadIdx_reg)
          2'h0:    emptyOfs_reg[8:0]  <= writeDataIn;
          2'h1:    emptyOfs_reg[15:9] <= writeDataIn[6:0];
          2'h2:    fullOfs_reg[8:0]   <= writeDataIn;
          default: fullOfs_reg[15:9]  <= writeDataIn[6:0];
        endcase
        loadIdx_reg <= loadIdx_reg + 2'h1;
      end
      if (doOfsRead) begin
        readIdx_reg <= readIdx_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered flags
  // ----------------------------------------------------------------
  wire [17:0] countPlusM = {1'b0, wordCount} + {2'h0, fullOfs_reg};
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fullFlag_reg    <= 1'b1;
      emptyFlag_reg   <= 1'b0;
      almostFull_reg  <= 1'b1;
      almostEmpty_reg <= 1'b0;
      halfFull_reg    <= 1'b1;
    end else begin
      // Standard: low when full; fall-through: low while space remains
      fullFlag_reg    <= fallThrough_reg ? memFull : ~memFull;
      // Standard: low when empty; fall-through: low while output valid
      if (fallThrough_reg) begin
        emptyFlag_reg <= ~outValid_reg | (rtHold_reg != 2'h0);
      end else begin
        emptyFlag_reg <= ~memEmpty & (rtHold_reg == 2'h0);
      end
      almostFull_reg  <= ~(countPlusM > {1'b0, `DCF_DEPTH});
      almostEmpty_reg <= ~(wordCount < {1'b0, emptyOfs_reg});
      halfFull_reg    <= ~(wordCount > `DCF_HALF);
    end
  end

  assign readDataOut        = dataOut_reg;
  assign readDataOeN        = outputEnableN;
  assign fullOrInputReady   = fullFlag_reg;
  assign emptyOrOutputReady = emptyFlag_reg;
  assign almostFullN        = almostFull_reg;
  assign almostEmptyN       = almostEmpty_reg;
  assign halfFullN          = halfFull_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg        awHeld_reg;
  reg [3:0]  awAddr_reg;
  reg        wHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;
  reg        bValid_reg;
  reg [1:0]  bResp_reg;
  reg        rValid_reg;
  reg [31:0] rData_reg;
  reg [1:0]  rResp_reg;

  assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
  assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = ~rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  wire awTake   = s_axi_awvalid & s_axi_awready;
  wire wTake    = s_axi_wvalid & s_axi_wready;
  wire wrFire   = awHeld_reg & wHeld_reg;
  wire wrMapped = (awAddr_reg == `DCF_REG_STATUS) | (awAddr_reg == `DCF_REG_OFFSETS) |
                  (awAddr_reg == `DCF_REG_CONTROL);

  // Read data mux over the status registers
  reg [31:0] rdMux;
  reg        rdMapped;
  always @* begin
    rdMux    = 32'h00000000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      `DCF_REG_STATUS: begin
        rdMux[16:0]             = wordCount;
        rdMux[`DCF_ST_EMPTY]    = memEmpty;
        rdMux[`DCF_ST_FULL]     = memFull;
        rdMux[`DCF_ST_FALL]     = fallThrough_reg;
        rdMux[`DCF_ST_SERIAL]   = serialMethod_reg;
      end
      `DCF_REG_OFFSETS: rdMux = {fullOfs_reg, emptyOfs_reg};
      `DCF_REG_CONTROL: rdMux = 32'h00000000;
      default:          rdMapped = 1'b0;
    endcase
  end

  // Write and read channel sequencing
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_reg      <= 1'b0;
      awAddr_reg      <= 4'h0;
      wHeld_reg       <= 1'b0;
      wData_reg       <= 32'h00000000;
      wStrb_reg       <= 4'h0;
      bValid_reg      <= 1'b0;
      bResp_reg       <= `DCF_RESP_OKAY;
      rValid_reg      <= 1'b0;
      rData_reg       <= 32'h00000000;
      rResp_reg       <= `DCF_RESP_OKAY;
      softPartial_reg <= 1'b0;
    end else begin
      softPartial_reg <= 1'b0;
      if (awTake) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg  <= wrMapped ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        // Control write pulses a partial reset for one cycle
        if (awAddr_reg == `DCF_REG_CONTROL && wStrb_reg[0]) begin
          softPartial_reg <= wData_reg[`DCF_CTL_PRST];
        end
      end else if (bValid_reg & s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
      if (s_axi_arvalid & ~rValid_reg) begin
        rValid_reg <= 1'b1;
        rData_reg  <= rdMux;
        rResp_reg  <= rdMapped ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
      end else if (rValid_reg & s_axi_rready) begin
        rValid_reg <= 1'b0;
      end
    end
  end

endmodule

// >>> dcf_fifo_tb_top.sv
// Self-checking bench for the dual-clock FIFO
`timescale 1ns/1ps
`include "dcf_defines.vh"
module dcf_fifo_tb_top;
  logic        clk_sys = 1'h0, rst = 1'h1, modeSelectSerialIn = 1'h0, offsetLoadN = 1'h1;
  logic        outputEnableN = 1'h0, fullResetN = 1'h0, partialResetN = 1'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, ofs;
  logic [15:0] hw;
  logic [8:0]  pat [3] = '{9'h1a5, 9'h05a, 9'h100};
  wire         writeClk, writeEnableN, serialLoadEnableN, readClk, readEnableN, rewindN;
  wire  [8:0]  writeDataIn, readDataOut;
  wire         readDataOeN, fullOrInputReady, emptyOrOutputReady, almostFullN, almostEmptyN;
  wire         halfFullN, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          errors = 0, nCompared = 0;
  dcf_fifo dcf_fifo_i (.clk_sys, .rst, .writeClk, .writeEnableN, .writeDataIn,
    .serialLoadEnableN, .modeSelectSerialIn, .offsetLoadN, .readClk, .readEnableN,
    .outputEnableN, .fullResetN, .partialResetN, .rewindN, .readDataOut, .readDataOeN,
    .fullOrInputReady, .emptyOrOutputReady, .almostFullN, .almostEmptyN, .halfFullN,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  dcf_partner dcf_partner_i (.clk_sys, .writeClk, .writeEnableN, .serialLoadEnableN,
    .writeDataIn, .readClk, .readEnableN, .rewindN);
  // Clock and watchdog
  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    repeat (6000) @(posedge clk_sys);
    errors++;
    complete_run;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, e);
    nCompared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic ld(input logic v);
    @(posedge clk_sys);
    offsetLoadN <= v;
  endtask
  task automatic mres(input logic m, input logic l);
    @(posedge clk_sys);
    fullResetN <= 1'h0;
    modeSelectSerialIn <= m;
    offsetLoadN <= l;
    repeat (2) @(posedge clk_sys);
    fullResetN <= 1'h1;
    @(negedge clk_sys);
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw;
    ga = 1'h0;
    gw = 1'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ga && gw)) begin
      @(negedge clk_sys);
      ga |= s_axi_awready;
      gw |= s_axi_wready;
      @(posedge clk_sys);
      if (ga) s_axi_awvalid <= 1'h0;
      if (gw) s_axi_wvalid <= 1'h0;
    end
    do @(negedge clk_sys); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge clk_sys);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axiRd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er,
                       input bit cd);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'h0;
    do @(negedge clk_sys); while (!s_axi_rvalid);
    chk(s_axi_rresp, er);
    if (cd) chk(s_axi_rdata, ed);
    @(posedge clk_sys);
    s_axi_rready <= 1'h0;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    mres(1'h0, 1'h1);
    axiRd(`DCF_REG_STATUS, 32'h0012_0000, `DCF_RESP_OKAY, 1);
    axiRd(`DCF_REG_OFFSETS, 32'h03ff_03ff, `DCF_RESP_OKAY, 1);
    axiRd(4'hc, 32'h0, `DCF_RESP_SLVERR, 0);
    axiWr(4'hc, 32'h1, `DCF_RESP_SLVERR);
    dcf_partner_i.gap = 2;
    for (int i = 0; i < 3; i++) dcf_partner_i.wr(pat[i], 1'h0, 1'h1);
    dcf_partner_i.gap = 0;
    w(2);
    // Serial method still selected from the first full reset
    axiRd(`DCF_REG_STATUS, 32'h0010_0003, `DCF_RESP_OKAY, 1);
    chk(emptyOrOutputReady, 1'h1);
    for (int i = 0; i < 4; i++) begin
      dcf_partner_i.rd(1'h0, 1'h1);
      chk(readDataOut, pat[i > 2 ? 2 : i]);
    end
    w(2);
    chk(emptyOrOutputReady, 1'h0);
    dcf_partner_i.rd(1'h1, 1'h0);
    // Words are back, but the empty flag is held low for a while
    w(1);
    chk(emptyOrOutputReady, 1'h0);
    repeat (3) dcf_partner_i.rd(1'h1, 1'h1);
    w(2);
    chk(emptyOrOutputReady, 1'h1);
    dcf_partner_i.rd(1'h0, 1'h1);
    chk(readDataOut, pat[0]);
    $display("test data and rewind done");
    axiWr(`DCF_REG_CONTROL, 32'h1, `DCF_RESP_OKAY);
    axiRd(`DCF_REG_STATUS, 32'h0012_0000, `DCF_RESP_OKAY, 1);
    // Large full offset so that five words already reach almost-full
    ofs = 32'hfffc_0005;
    ld(1'h0);
    for (int b = 0; b < 32; b++) begin
      @(posedge clk_sys);
      modeSelectSerialIn <= ofs[b];
      dcf_partner_i.wr(9'h000, 1'h1, 1'h0);
    end
    axiRd(`DCF_REG_OFFSETS, ofs, `DCF_RESP_OKAY, 1);
    for (int i = 0; i < 4; i++) begin
      hw = ofs[16 * (i / 2) +: 16];
      dcf_partner_i.rd(1'h0, 1'h1);
      chk(readDataOut, i % 2 ? {2'h0, hw[15:9]} : hw[8:0]);
    end
    ld(1'h1);
    for (int i = 0; i < 5; i++) begin
      dcf_partner_i.wr(9'(i), 1'h0, 1'h1);
      w(2);
      chk(almostEmptyN, i == 4);
      chk(almostFullN, i != 4);
    end
    chk({halfFullN, almostFullN}, 2'h2);
    // Partial reset on the pin clears words and keeps the offsets
    @(posedge clk_sys);
    partialResetN <= 1'h0;
    repeat (2) @(posedge clk_sys);
    partialResetN <= 1'h1;
    axiRd(`DCF_REG_STATUS, 32'h0012_0000, `DCF_RESP_OKAY, 1);
    axiRd(`DCF_REG_OFFSETS, ofs, `DCF_RESP_OKAY, 1);
    $display("test offsets done");
    mres(1'h1, 1'h0);
    axiRd(`DCF_REG_STATUS, 32'h000a_0000, `DCF_RESP_OKAY, 1);
    axiRd(`DCF_REG_OFFSETS, 32'h007f_007f, `DCF_RESP_OKAY, 1);
    chk({fullOrInputReady, emptyOrOutputReady}, 2'h1);
    ofs = 32'h0010_0003;
    ld(1'h0);
    for (int i = 0; i < 4; i++) begin
      hw = ofs[16 * (i / 2) +: 16];
      dcf_partner_i.wr(i % 2 ? {2'h0, hw[15:9]} : hw[8:0], 1'h0, 1'h1);
    end
    axiRd(`DCF_REG_OFFSETS, ofs, `DCF_RESP_OKAY, 1);
    ld(1'h1);
    dcf_partner_i.wr(9'h0c3, 1'h0, 1'h1);
    w(2);
    // Two transitions seen so far: the word must not have fallen yet
    dcf_partner_i.rd(1'h1, 1'h1);
    chk(readDataOut, 9'h000);
    dcf_partner_i.rd(1'h1, 1'h1);
    w(2);
    chk(readDataOut, 9'h0c3);
    chk(emptyOrOutputReady, 1'h0);
    @(posedge clk_sys);
    outputEnableN <= 1'h1;
    w(1);
    chk(readDataOeN, 1'h1);
    $display("test fall-through done");
    complete_run;
  end
endmodule

// >>> dcf_partner.sv
// Producer and consumer model on the FIFO pin ports
`timescale 1ns/1ps
module dcf_partner (
  input  wire        clk_sys,
  output logic       writeClk = 1'h0,
  output logic       writeEnableN = 1'h1,
  output logic       serialLoadEnableN = 1'h1,
  output logic [8:0] writeDataIn = 9'h000,
  output logic       readClk = 1'h0,
  output logic       readEnableN = 1'h1,
  output logic       rewindN = 1'h1
);
  int gap = 0;  // Idle cycles before a strobe
  // Write strobe, qualifiers held over the sampling edge
  task automatic wr(input logic [8:0] d, input logic wenN, input logic senN);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    writeClk <= 1'h1;
    writeEnableN <= wenN;
    serialLoadEnableN <= senN;
    writeDataIn <= d;
    @(posedge clk_sys);
    writeClk <= 1'h0;
    writeEnableN <= 1'h1;
    serialLoadEnableN <= 1'h1;
    writeDataIn <= ~d;  // Released bus shows no stale word
    @(negedge clk_sys);
  endtask
  // Read strobe with optional rewind
  task automatic rd(input logic renN, input logic rtN);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    readClk <= 1'h1;
    readEnableN <= renN;
    rewindN <= rtN;
    @(posedge clk_sys);
    readClk <= 1'h0;
    readEnableN <= 1'h1;
    rewindN <= 1'h1;
    @(negedge clk_sys);
  endtask
endmodule

// >>> dcf_props.sv
// Checker for reset, flag, output and bus timing of the FIFO
`timescale 1ns/1ps
module dcf_props (
  input wire       clk_sys,
  input wire       rst,
  input wire       readClk,
  input wire       modeSelectSerialIn,
  input wire       outputEnableN,
  input wire       fullResetN,
  input wire       partialResetN,
  input wire       s_axi_wvalid,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire [8:0] readDataOut,
  input wire       readDataOeN,
  input wire       fullOrInputReady,
  input wire       emptyOrOutputReady,
  input wire       almostFullN,
  input wire       almostEmptyN,
  input wire       halfFullN
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Reset and idle sequences
  // ----------------------------------------
  sequence fullRst2;
    !fullResetN ##1 !fullResetN;
  endsequence
  sequence partRst2;
    !partialResetN ##1 !partialResetN;
  endsequence
  sequence rdIdle;
    (!readClk && fullResetN && partialResetN && !s_axi_wvalid)[*4];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  oe_drive_a: assert property (readDataOeN == outputEnableN)
    else $error("output enable not followed");
  full_flags_a: assert property (fullRst2 |=> !almostEmptyN && halfFullN && almostFullN)
    else $error("flags wrong after full reset");
  reset_mode_a: assert property (fullRst2 |=> emptyOrOutputReady == $past(modeSelectSerialIn)
    && fullOrInputReady != $past(modeSelectSerialIn)) else $error("mode flags wrong");
  part_flags_a: assert property (partRst2 |=> !almostEmptyN && halfFullN)
    else $error("flags wrong after partial reset");
  out_clear_a: assert property (!fullResetN || !partialResetN |=> readDataOut == 9'h000)
    else $error("output not cleared");
  out_hold_a: assert property (rdIdle |-> $stable(readDataOut))
    else $error("output moved without read");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
endmodule

bind dcf_fifo dcf_props dcf_props_i (.clk_sys, .rst, .readClk, .modeSelectSerialIn,
  .outputEnableN, .fullResetN, .partialResetN, .s_axi_wvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .readDataOut, .readDataOeN, .fullOrInputReady,
  .emptyOrOutputReady, .almostFullN, .almostEmptyN, .halfFullN);
